// ==== core/fsp_pkg.sv ====
// Operation
// - Status bit 0 is busy during status write, program or erase cycles.
// - Status bit 1 mirrors write enable latch; clear latch refuses writes.
// - Nonzero block protect bits block program and erase inside the region.
// - Block protect bits change by status write only outside hardware protection.
// - Chip erase runs only with all protect bits and boot lock clear.
// - Boot lock enable locks one sector or block chosen by select bits.
// - Status protect bit with write protect low rejects status writes.
// - OTP mode status byte shows lock, pin disable, pin select, granularity, side.
// - Top/bottom select: 0 protects from top, 1 from bottom; default 0.
// - Granularity bit: 1 locks 4KB sector, 0 a 64KB block; default 0.
// - Pin disable bit 1 turns off write protect and hold/reset pins.
// - Quad mode disables write protect and hold/reset pin functions.
// - Pin select bit: 0 means hold input, 1 means reset input.
// - With pins disabled the shared pin ignores hold and reset.
// - Secure sector lock set refuses OTP sector program and erase; set once.
// - Opcode 95h streams the configuration byte repeatedly, any time.
// - Config bits 5:4 pick dummy bytes 3, 2, 4 or 5.
// - Quad mode dummy bytes last two clocks each.
// - Config bits 3:2 pick drive strength 67, 100, 50 or 33 percent.
// - Configuration bits are volatile; bits 7, 6, 1, 0 reserved.
// - Status write needs a prior write enable; otherwise ignored.
// - Opcode 05h streams the status byte at any time, even busy.
package fsp_pkg;

  localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OPC_READ_STATUS  = 8'h05;
  localparam logic [7:0] OPC_READ_CONFIG  = 8'h95;
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;

  // Status field positions
  localparam int SB_BUSY  = 0;
  localparam int SB_WEL   = 1;
  localparam int SB_BP_LO = 2;
  localparam int SB_EBL   = 6;
  localparam int SB_SRP   = 7;
  localparam int SB_TB    = 3;
  localparam int SB_G4K   = 4;
  localparam int SB_HOLD_RESET_PIN_SELECT  = 5;
  localparam int SB_CONTROL_PINS_DISABLE = 6;
  localparam int SB_OLOCK = 7;

  // Configuration field positions and reset value
  localparam int         CB_DUMMY_LO = 4;
  localparam int         CB_DRIVE_LO = 2;
  localparam logic [7:0] CFG_WR_MASK = 8'h3c;
  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam logic [7:0] STAT_RESET  = 8'h00;

  // Address bit positions of operation and lock granules
  localparam int A_PAGE  = 8;
  localparam int A_SECT  = 12;
  localparam int A_HALF  = 15;
  localparam int A_BLOCK = 16;
  localparam int A_TOP   = 23;

  localparam int WRITE_STATUS_CMD_CYCLES = 16;

  typedef enum logic [2:0] {
    FSP_PAGE, FSP_QPAGE, FSP_SECT, FSP_HALF, FSP_BLOCK, FSP_CHIP
  } fsp_kind_t;

  typedef struct packed {
    logic [7:0] opc;
    logic [7:0] data;
    logic [1:0] nbytes;
    logic [2:0] nbits;
  } fsp_frame_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] config_b;
  } fsp_regs_t;

  typedef struct packed {
    logic       req;
    fsp_kind_t  kind;
    logic [23:0] addr;
    logic       otp;
  } fsp_pe_req_t;

endpackage : fsp_pkg

// ==== core/fsp_status_regs.sv ====
`timescale 1ns/100ps
module fsp_status_regs #(
  parameter int WRITE_STATUS_CMD_CYCLES = fsp_pkg::WRITE_STATUS_CMD_CYCLES
) (
  input  wire logic           clock_i,        // System clock
  input  wire logic           sys_rst_i,      // Sync reset, high
  input  wire logic           spi_clk_i,      // Link serial clock
  input  wire logic           spi_cs_n_i,     // Chip select, low
  input  wire logic           spi_mosi_i,     // Serial data in
  output logic                spi_miso_o,     // Serial data out
  output logic                spi_miso_oe_o,  // Data out enable
  input  wire logic           wp_n_i,         // Write protect pin, low
  input  wire logic           hold_n_i,       // Hold/reset pin, low
  input  wire logic           otp_mode_i,     // OTP mode active
  input  wire logic           quad_mode_i,    // Quad command mode active
  input  wire fsp_pkg::fsp_pe_req_t pe_i,     // Program/erase request
  input  wire logic           pe_done_i,      // Engine finished
  input  wire logic           cfg_wr_i,       // Config byte write
  input  wire logic [7:0]     cfg_data_i,     // Config write data
  output logic                pe_grant_o,     // Request granted
  output logic                pe_deny_o,      // Request refused
  output logic [7:0]          stat_byte_o,    // Status byte view
  output logic [7:0]          cfg_byte_o,     // Config byte view
  output logic                hpm_o,          // Hardware protection
  output logic                hold_act_o,     // Hold asserted
  output logic                rst_act_o,      // Pin reset asserted
  output logic [3:0]          dummy_clks_o,   // Dummy clock count
  output logic [1:0]          drive_sel_o     // Drive strength code
);

  ////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [3:0] dummy_bytes(input logic [1:0] code);
    case (code)
      2'h0:    dummy_bytes = 4'h3;
      2'h1:    dummy_bytes = 4'h2;
      2'h2:    dummy_bytes = 4'h4;
      default: dummy_bytes = 4'h5;
    endcase
  endfunction : dummy_bytes

  function automatic int op_lsb(input fsp_pkg::fsp_kind_t k);
    case (k)
      fsp_pkg::FSP_SECT:  op_lsb = fsp_pkg::A_SECT;
      fsp_pkg::FSP_HALF:  op_lsb = fsp_pkg::A_HALF;
      fsp_pkg::FSP_BLOCK: op_lsb = fsp_pkg::A_BLOCK;
      default:            op_lsb = fsp_pkg::A_PAGE;
    endcase
  endfunction : op_lsb

  // True when the top (tb 0) or bottom (tb 1) granule of size 2**lo
  // overlaps the operation's range.
  function automatic logic edge_hit(input logic [23:0] a, input int lo,
                                    input logic tb);
    logic hit;
    hit = 1'b1;
    for (int i = fsp_pkg::A_SECT; i <= fsp_pkg::A_TOP; i++) begin
      if (i >= lo && a[i] != ~tb)
        hit = 1'b0;
    end
    edge_hit = hit;
  endfunction : edge_hit

  // Region grows in 64KB blocks from one edge: 2**(bp-1) blocks, at most 256
  function automatic logic bp_hit(input logic [23:0] a, input logic [3:0] bp,
                                  input logic tb);
    logic [8:0] n;
    logic [8:0] blk;
    n   = (bp > 4'h8) ? 9'h100 : 9'(9'h1 << (bp - 4'h1));
    blk = {1'b0, a[23:16]};
    if (bp == 4'h0)
      bp_hit = 1'b0;
    else if (tb)
      bp_hit = blk < n;
    else
      bp_hit = blk >= (9'h100 - n);
  endfunction : bp_hit

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [1:0] wp_sync_ff;
  logic [1:0] hold_sync_ff;
  logic [2:0] cs_sync_ff;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wp_sync_ff   <= 2'h3;
      hold_sync_ff <= 2'h3;
      cs_sync_ff   <= 3'h7;
    end else begin
      wp_sync_ff   <= {wp_sync_ff[0], wp_n_i};
      hold_sync_ff <= {hold_sync_ff[0], hold_n_i};
      cs_sync_ff   <= {cs_sync_ff[1:0], spi_cs_n_i};
    end
  end

  logic frame_end;
  assign frame_end = cs_sync_ff[1] & ~cs_sync_ff[2];

  ////////////////////////////////////////////////////////////////////////
  // Link domain: shift in opcode and data, stream registers out

  logic [2:0]          bcnt_ff;
  logic [1:0]          nbyte_ff;
  logic [7:0]          shin_ff;
  logic [7:0]          opc_ff;
  logic [7:0]          data_ff;
  fsp_pkg::fsp_regs_t  mirror_ff;
  logic [1:0]          req_sync_ff;
  logic                ack_ff;
  fsp_pkg::fsp_regs_t  shadow_ff;
  logic                req_ff;
  logic [2:0]          end_bits_ff;
  logic [1:0]          end_bytes_ff;

  // Frame counters clear while chip select is high, so the link side
  // needs no edges outside a frame.
  always_ff @(posedge spi_clk_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin
      bcnt_ff  <= 3'h0;
      nbyte_ff <= 2'h0;
    end else begin
      bcnt_ff <= bcnt_ff + 3'h1;
      if (bcnt_ff == 3'h7 && nbyte_ff != 2'h3)
        nbyte_ff <= nbyte_ff + 2'h1;
    end
  end

  always_ff @(posedge spi_clk_i) begin
    shin_ff <= {shin_ff[6:0], spi_mosi_i};
    // Counters clear as select rises, so the frame length is kept here
    end_bits_ff  <= bcnt_ff + 3'h1;
    end_bytes_ff <= (bcnt_ff == 3'h7 && nbyte_ff != 2'h3) ?
                    nbyte_ff + 2'h1 : nbyte_ff;
    if (bcnt_ff == 3'h7 && nbyte_ff == 2'h0)
      opc_ff <= {shin_ff[6:0], spi_mosi_i};
    if (bcnt_ff == 3'h7 && nbyte_ff == 2'h1)
      data_ff <= {shin_ff[6:0], spi_mosi_i};
  end

  // Register snapshot handshake, link end. Core reset clears it while the
  // link clock is parked; an unknown ack would stall the handshake.
  always_ff @(posedge spi_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_sync_ff <= 2'h0;
      ack_ff      <= 1'b0;
      mirror_ff   <= '{status: fsp_pkg::STAT_RESET,
                       config_b: fsp_pkg::CFG_RESET};
    end else begin
      req_sync_ff <= {req_sync_ff[0], req_ff};
      if (req_sync_ff[1] != ack_ff) begin
        mirror_ff <= shadow_ff;
        ack_ff    <= req_sync_ff[1];
      end
    end
  end

  logic       rd_stat;
  logic       rd_cfg;
  logic [7:0] out_byte;
  assign rd_stat  = opc_ff == fsp_pkg::OPC_READ_STATUS;
  assign rd_cfg   = opc_ff == fsp_pkg::OPC_READ_CONFIG;
  assign out_byte = rd_cfg ? mirror_ff.config_b : mirror_ff.status;

  // Byte repeats for as long as the host keeps clocking
  always_ff @(negedge spi_clk_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin
      spi_miso_o    <= 1'b0;
      spi_miso_oe_o <= 1'b0;
    end else begin
      spi_miso_oe_o <= (nbyte_ff != 2'h0) & (rd_stat | rd_cfg);
      spi_miso_o    <= out_byte[~bcnt_ff];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core domain registers

  logic                wel_ff;
  logic [3:0]          bp_ff;
  logic                ebl_ff;
  logic                srp_ff;
  logic                tb_ff;
  logic                g4k_ff;
  logic                hold_reset_pin_select_ff;
  logic                control_pins_disable_ff;
  logic                olock_ff;
  logic [7:0]          cfg_ff;
  logic                eng_busy_ff;
  logic [15:0]         wr_cnt_ff;
  logic [1:0]          ack_sync_ff;
  fsp_pkg::fsp_frame_t frm;

  // The frame fields are quiet once chip select is high: the link clock
  // has stopped, and the synchronised edge lands two cycles later.
  assign frm = '{opc: opc_ff, data: data_ff, nbytes: end_bytes_ff,
                 nbits: end_bits_ff};

  logic write_in_progress_flag;
  logic pins_on;
  logic hardware_protected_mode;
  logic do_write_enable_cmd;
  logic do_wrdi;
  logic do_write_status_cmd;
  assign write_in_progress_flag     = eng_busy_ff | (wr_cnt_ff != 16'h0);
  assign pins_on = ~control_pins_disable_ff & ~quad_mode_i;
  assign hardware_protected_mode     = srp_ff & ~wp_sync_ff[1] & pins_on;
  assign do_write_enable_cmd = frame_end && frm.opc == fsp_pkg::OPC_WRITE_ENABLE &&
                   frm.nbytes == 2'h1 && frm.nbits == 3'h0 && !write_in_progress_flag;
  assign do_wrdi = frame_end && frm.opc == fsp_pkg::OPC_WRITE_DISABLE &&
                   frm.nbytes == 2'h1 && frm.nbits == 3'h0 && !write_in_progress_flag;
  // Chip select must rise right after the eighth data bit
  assign do_write_status_cmd = frame_end && frm.opc == fsp_pkg::OPC_WRITE_STATUS &&
                   frm.nbytes == 2'h2 && frm.nbits == 3'h0 &&
                   wel_ff && !hardware_protected_mode && !write_in_progress_flag;

  logic pe_ok;
  always_comb begin
    pe_ok = wel_ff && !write_in_progress_flag;
    if (pe_i.kind == fsp_pkg::FSP_CHIP) begin
      if (bp_ff != 4'h0 || ebl_ff)
        pe_ok = 1'b0;
    end else begin
      if (bp_hit(pe_i.addr, bp_ff, tb_ff))
        pe_ok = 1'b0;
      if (ebl_ff && edge_hit(pe_i.addr, (op_lsb(pe_i.kind) >
          (g4k_ff ? fsp_pkg::A_SECT : fsp_pkg::A_BLOCK)) ?
          op_lsb(pe_i.kind) : (g4k_ff ? fsp_pkg::A_SECT :
          fsp_pkg::A_BLOCK), tb_ff))
        pe_ok = 1'b0;
    end
    if (pe_i.otp && olock_ff)
      pe_ok = 1'b0;
  end

  // Write enable latch and engine busy
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wel_ff      <= 1'b0;
      eng_busy_ff <= 1'b0;
      pe_grant_o  <= 1'b0;
      pe_deny_o   <= 1'b0;
    end else begin
      pe_grant_o <= pe_i.req & pe_ok;
      pe_deny_o  <= pe_i.req & ~pe_ok;
      if (pe_i.req && pe_ok)
        eng_busy_ff <= 1'b1;
      else if (pe_done_i)
        eng_busy_ff <= 1'b0;
      if (do_write_enable_cmd)
        wel_ff <= 1'b1;
      else if (do_wrdi || (pe_done_i && eng_busy_ff) ||
               wr_cnt_ff == 16'h1)
        wel_ff <= 1'b0;
    end
  end

  // Status write cycle timer
  always_ff @(posedge clock_i) begin
    if (sys_rst_i)
      wr_cnt_ff <= 16'h0;
    else if (do_write_status_cmd)
      wr_cnt_ff <= 16'(WRITE_STATUS_CMD_CYCLES);
    else if (wr_cnt_ff != 16'h0)
      wr_cnt_ff <= wr_cnt_ff - 16'h1;
  end

  // Protection and OTP bits; OTP bits only ever go from 0 to 1
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      bp_ff    <= 4'h0;
      ebl_ff   <= 1'b0;
      srp_ff   <= 1'b0;
      tb_ff    <= 1'b0;
      g4k_ff   <= 1'b0;
      hold_reset_pin_select_ff  <= 1'b0;
      control_pins_disable_ff <= 1'b0;
      olock_ff <= 1'b0;
    end else if (do_write_status_cmd && !otp_mode_i) begin
      bp_ff  <= frm.data[fsp_pkg::SB_BP_LO +: 4];
      ebl_ff <= frm.data[fsp_pkg::SB_EBL];
      srp_ff <= frm.data[fsp_pkg::SB_SRP];
    end else if (do_write_status_cmd) begin
      tb_ff    <= tb_ff    | frm.data[fsp_pkg::SB_TB];
      g4k_ff   <= g4k_ff   | frm.data[fsp_pkg::SB_G4K];
      hold_reset_pin_select_ff  <= hold_reset_pin_select_ff  | frm.data[fsp_pkg::SB_HOLD_RESET_PIN_SELECT];
      control_pins_disable_ff <= control_pins_disable_ff | frm.data[fsp_pkg::SB_CONTROL_PINS_DISABLE];
      olock_ff <= olock_ff | frm.data[fsp_pkg::SB_OLOCK];
    end
  end

  // Volatile config byte; reserved bits never stored
  always_ff @(posedge clock_i) begin
    if (sys_rst_i)
      cfg_ff <= fsp_pkg::CFG_RESET;
    else if (cfg_wr_i)
      cfg_ff <= cfg_data_i & fsp_pkg::CFG_WR_MASK;
  end

  logic [7:0] stat_live;
  always_comb begin
    stat_live = fsp_pkg::STAT_RESET;
    stat_live[fsp_pkg::SB_BUSY] = write_in_progress_flag;
    stat_live[fsp_pkg::SB_WEL]  = wel_ff;
    if (otp_mode_i) begin
      stat_live[fsp_pkg::SB_TB]    = tb_ff;
      stat_live[fsp_pkg::SB_G4K]   = g4k_ff;
      stat_live[fsp_pkg::SB_HOLD_RESET_PIN_SELECT]  = hold_reset_pin_select_ff;
      stat_live[fsp_pkg::SB_CONTROL_PINS_DISABLE] = control_pins_disable_ff;
      stat_live[fsp_pkg::SB_OLOCK] = olock_ff;
    end else begin
      stat_live[fsp_pkg::SB_BP_LO +: 4] = bp_ff;
      stat_live[fsp_pkg::SB_EBL]        = ebl_ff;
      stat_live[fsp_pkg::SB_SRP]        = srp_ff;
    end
  end

  // Register snapshot handshake, core end. A change that lands while the
  // link clock is stopped reaches the link within the opcode byte.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ack_sync_ff <= 2'h0;
      req_ff      <= 1'b0;
      shadow_ff   <= '{status: fsp_pkg::STAT_RESET,
                       config_b: fsp_pkg::CFG_RESET};
    end else begin
      ack_sync_ff <= {ack_sync_ff[0], ack_ff};
      if (ack_sync_ff[1] == req_ff &&
          shadow_ff != {stat_live, cfg_ff}) begin
        shadow_ff <= '{status: stat_live, config_b: cfg_ff};
        req_ff    <= ~req_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      stat_byte_o  <= fsp_pkg::STAT_RESET;
      cfg_byte_o   <= fsp_pkg::CFG_RESET;
      hpm_o        <= 1'b0;
      hold_act_o   <= 1'b0;
      rst_act_o    <= 1'b0;
      dummy_clks_o <=
        dummy_bytes(fsp_pkg::CFG_RESET[fsp_pkg::CB_DUMMY_LO +: 2]);
      drive_sel_o  <= 2'h0;
    end else begin
      stat_byte_o <= stat_live;
      cfg_byte_o  <= cfg_ff;
      hpm_o       <= hardware_protected_mode;
      hold_act_o  <= pins_on & ~hold_reset_pin_select_ff & ~hold_sync_ff[1];
      rst_act_o   <= pins_on & hold_reset_pin_select_ff & ~hold_sync_ff[1];
      dummy_clks_o <= quad_mode_i ?
        4'(dummy_bytes(cfg_ff[fsp_pkg::CB_DUMMY_LO +: 2]) << 1) :
        dummy_bytes(cfg_ff[fsp_pkg::CB_DUMMY_LO +: 2]);
      drive_sel_o <= cfg_ff[fsp_pkg::CB_DRIVE_LO +: 2];
    end
  end

endmodule : fsp_status_regs

// ==== verif/fsp_checker.sv ====
`timescale 1ns/100ps
module fsp_checker #(
  parameter int WRITE_STATUS_CMD_CYCLES = 16
) (
  input wire logic                 clock_i,      // Clock
  input wire logic                 sys_rst_i,    // Reset
  input wire logic                 otp_mode_i,   // OTP mode
  input wire logic                 quad_mode_i,  // Quad mode
  input wire fsp_pkg::fsp_pe_req_t pe_i,         // Request
  input wire logic                 pe_done_i,    // Engine done
  input wire logic                 cfg_wr_i,     // Config write
  input wire logic [7:0]           cfg_data_i,   // Config data
  input wire logic                 pe_grant_o,   // Grant
  input wire logic                 pe_deny_o,    // Deny
  input wire logic [7:0]           stat_byte_o,  // Status view
  input wire logic [7:0]           cfg_byte_o,   // Config view
  input wire logic                 hold_act_o,   // Hold active
  input wire logic                 rst_act_o,    // Pin reset active
  input wire logic [3:0]           dummy_clks_o, // Dummy count
  input wire logic [1:0]           drive_sel_o   // Drive code
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  // Quad mode spends two clocks on every dummy byte
  function automatic logic [3:0] dmy(input logic [1:0] c, input logic q);
    logic [3:0] b;
    b = (c == 2'h0) ? 4'h3 : (c == 2'h1) ? 4'h2 : {2'h0, c} + 4'h2;
    return q ? {b[2:0], 1'b0} : b;
  endfunction : dmy

  sequence s_chip_locked;
    pe_i.req && pe_i.kind == fsp_pkg::FSP_CHIP && !otp_mode_i &&
      stat_byte_o[6:2] != 5'h00;
  endsequence
  sequence s_quad_held;
    quad_mode_i [*4];
  endsequence

  a_one_answer: assert property (
    pe_i.req |=> pe_grant_o ^ pe_deny_o)
    else $error("request not answered exactly once");
  a_grant_busy: assert property (
    pe_grant_o |=> stat_byte_o[0])
    else $error("grant without busy flag");
  a_chip_lock: assert property (
    s_chip_locked |=> pe_deny_o)
    else $error("chip erase not refused");
  a_done_clear: assert property (
    pe_done_i |-> ##2 stat_byte_o[1:0] == 2'h0)
    else $error("busy or latch left after done");
  a_cfg_store: assert property (
    cfg_wr_i |-> ##2
      cfg_byte_o == ($past(cfg_data_i, 2) & fsp_pkg::CFG_WR_MASK))
    else $error("config byte not stored");
  a_cfg_resv: assert property (
    (cfg_byte_o & ~fsp_pkg::CFG_WR_MASK) == 8'h00)
    else $error("reserved config bit set");
  a_drive_map: assert property (
    drive_sel_o == cfg_byte_o[3:2])
    else $error("drive code differs from config");
  a_dummy_map: assert property (
    $stable(cfg_byte_o) && $stable(quad_mode_i) &&
      $past(quad_mode_i, 2) == quad_mode_i |->
      dummy_clks_o == dmy(cfg_byte_o[5:4], quad_mode_i))
    else $error("dummy count wrong");
  a_quad_pins: assert property (
    s_quad_held |-> !hold_act_o && !rst_act_o)
    else $error("pin function active in quad mode");
  a_otp_resv: assert property (
    otp_mode_i [*3] |-> !stat_byte_o[2])
    else $error("reserved status bit set");
endmodule : fsp_checker

bind fsp_status_regs fsp_checker #(.WRITE_STATUS_CMD_CYCLES(WRITE_STATUS_CMD_CYCLES)) i_chk (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .otp_mode_i(otp_mode_i),
  .quad_mode_i(quad_mode_i), .pe_i(pe_i), .pe_done_i(pe_done_i),
  .cfg_wr_i(cfg_wr_i), .cfg_data_i(cfg_data_i), .pe_grant_o(pe_grant_o),
  .pe_deny_o(pe_deny_o), .stat_byte_o(stat_byte_o),
  .cfg_byte_o(cfg_byte_o), .hold_act_o(hold_act_o),
  .rst_act_o(rst_act_o), .dummy_clks_o(dummy_clks_o),
  .drive_sel_o(drive_sel_o));

// ==== verif/fsp_host_model.sv ====
`timescale 1ns/100ps
module fsp_host_model (
  output logic      spi_clk_o,   // Link clock
  output logic      spi_cs_n_o,  // Select, low
  output logic      spi_mosi_o,  // Data to device
  input  wire logic spi_miso_i,  // Data from device
  input  wire logic spi_oe_i     // Device drives data
);
  initial begin
    spi_clk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end

  // Clock parks low between frames; bits past 16 are filler
  task automatic xfer(input logic [15:0] tx, input int nb,
                      output logic [15:0] rx);
    rx = 16'h0000;
    spi_cs_n_o = 1'b0;
    for (int i = 0; i < nb; i++) begin
      spi_mosi_o = (i < 16) ? tx[15-i] : ~spi_mosi_o;
      #7.5;
      if (i >= 8)
        rx = {rx[14:0], spi_oe_i ? spi_miso_i : 1'bx};
      spi_clk_o = 1'b1;
      #7.5;
      spi_clk_o = 1'b0;
    end
    #7.5;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = ~spi_mosi_o;
  endtask : xfer
endmodule : fsp_host_model

// ==== verif/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  logic clock_i, sys_rst_i, wp_n_i, hold_n_i, otp_mode_i, quad_mode_i;
  logic spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_oe, hpm_o;
  logic pe_done_i, cfg_wr_i, pe_grant_o, pe_deny_o, hold_act_o, rst_act_o;
  logic [7:0]           cfg_data_i, stat_byte_o, cfg_byte_o;
  logic [3:0]           dummy_clks_o;
  logic [1:0]           drive_sel_o;
  logic [15:0]          rd;
  fsp_pkg::fsp_pe_req_t pe_i;
  int                   err_count = 0;
  int                   samples_checked = 0;

  fsp_status_regs #(.WRITE_STATUS_CMD_CYCLES(100)) i_dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .spi_clk_i(spi_clk),
    .spi_cs_n_i(spi_cs_n), .spi_mosi_i(spi_mosi), .spi_miso_o(spi_miso),
    .spi_miso_oe_o(spi_oe), .wp_n_i(wp_n_i), .hold_n_i(hold_n_i),
    .otp_mode_i(otp_mode_i), .quad_mode_i(quad_mode_i), .pe_i(pe_i),
    .pe_done_i(pe_done_i), .cfg_wr_i(cfg_wr_i), .cfg_data_i(cfg_data_i),
    .pe_grant_o(pe_grant_o), .pe_deny_o(pe_deny_o), .hpm_o(hpm_o),
    .stat_byte_o(stat_byte_o), .cfg_byte_o(cfg_byte_o),
    .hold_act_o(hold_act_o), .rst_act_o(rst_act_o),
    .dummy_clks_o(dummy_clks_o), .drive_sel_o(drive_sel_o));
  fsp_host_model i_host (
    .spi_clk_o(spi_clk), .spi_cs_n_o(spi_cs_n), .spi_mosi_o(spi_mosi),
    .spi_miso_i(spi_miso), .spi_oe_i(spi_oe));

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic clks(input int n);
    repeat (n) @(posedge clock_i);
  endtask : clks

  // Six idle clocks keep frames apart and let the core see select rise
  task automatic frm(input logic [7:0] op, dat, input int nb);
    i_host.xfer({op, dat}, nb, rd);
    clks(6);
  endtask : frm

  task automatic wt(input logic v);
    int k;
    k = 0;
    while (stat_byte_o[0] !== v && k < 300) begin
      @(negedge clock_i);
      k++;
    end
    if (k == 300) begin
      err_count++;
      tally_and_finish();
    end
    @(posedge clock_i);
  endtask : wt

  task automatic write_status_cmd(input logic [7:0] v);
    frm(fsp_pkg::OPC_WRITE_ENABLE, 8'h00, 8);
    frm(fsp_pkg::OPC_WRITE_STATUS, v, 16);
    wt(1'b0);
  endtask : write_status_cmd

  task automatic pe(input fsp_pkg::fsp_kind_t kd, input logic [23:0] ad,
                    input logic ot, we, ex);
    logic g, d;
    g = 1'b0;
    d = 1'b0;
    if (we)
      frm(fsp_pkg::OPC_WRITE_ENABLE, 8'h00, 8);
    @(posedge clock_i);
    pe_i <= '{1'b1, kd, ad, ot};
    @(posedge clock_i);
    pe_i.req <= 1'b0;
    repeat (3) begin
      @(negedge clock_i);
      g |= pe_grant_o;
      d |= pe_deny_o;
    end
    chk("pe_answer", {6'h00, g, d}, {6'h00, ex, !ex});
    if (g) begin
      chk("pe_busy", stat_byte_o & 8'h03, 8'h03);
      @(posedge clock_i);
      pe_done_i <= 1'b1;
      @(posedge clock_i);
      pe_done_i <= 1'b0;
      clks(3);
      chk("pe_end", stat_byte_o & 8'h03, 8'h00);
    end
  endtask : pe

  //////////////////////////////////////////////////////////////////////////
  task automatic t_wel();
    chk("stat_rst", stat_byte_o, fsp_pkg::STAT_RESET);
    frm(fsp_pkg::OPC_READ_STATUS, 8'h00, 32);
    chk("rd_rst", rd[7:0], 8'h00);
    pe(fsp_pkg::FSP_PAGE, 24'h000000, 1'b0, 1'b0, 1'b0);
    frm(fsp_pkg::OPC_WRITE_STATUS, 8'h3c, 16);
    chk("no_wel", stat_byte_o, 8'h00);
    frm(fsp_pkg::OPC_WRITE_ENABLE, 8'h00, 8);
    chk("wel", stat_byte_o, 8'h02);
    frm(fsp_pkg::OPC_WRITE_STATUS, 8'h3c, 16);
    frm(fsp_pkg::OPC_READ_STATUS, 8'h00, 32);
    chk("rd_busy", rd[7:0] & 8'h03, 8'h03);
    wt(1'b0);
    chk("bp_all", stat_byte_o, 8'h3c);
    $display("test latch done");
  endtask : t_wel

  task automatic t_prot();
    pe(fsp_pkg::FSP_CHIP, 24'h000000, 1'b0, 1'b1, 1'b0);
    write_status_cmd(8'h04);
    for (int k = 0; k < 5; k++)
      pe(fsp_pkg::fsp_kind_t'(k[2:0]), 24'hff0000, 1'b0, 1'b1, 1'b0);
    pe(fsp_pkg::FSP_PAGE, 24'h000000, 1'b0, 1'b1, 1'b1);
    write_status_cmd(8'h40);
    pe(fsp_pkg::FSP_CHIP, 24'h000000, 1'b0, 1'b1, 1'b0);
    pe(fsp_pkg::FSP_BLOCK, 24'hff0000, 1'b0, 1'b1, 1'b0);
    pe(fsp_pkg::FSP_SECT, 24'h010000, 1'b0, 1'b1, 1'b1);
    write_status_cmd(8'h00);
    pe(fsp_pkg::FSP_CHIP, 24'h000000, 1'b0, 1'b1, 1'b1);
    $display("test protect done");
  endtask : t_prot

  task automatic t_hpm();
    write_status_cmd(8'h80);
    wp_n_i <= 1'b0;
    clks(6);
    chk("hpm", {7'h00, hpm_o}, 8'h01);
    write_status_cmd(8'h00);
    chk("hpm_keep", stat_byte_o, 8'h82);
    quad_mode_i <= 1'b1;
    hold_n_i <= 1'b0;
    clks(6);
    chk("quad", {6'h00, hpm_o, hold_act_o}, 8'h00);
    quad_mode_i <= 1'b0;
    hold_n_i <= 1'b1;
    wp_n_i <= 1'b1;
    clks(6);
    write_status_cmd(8'h00);
    chk("hpm_off", stat_byte_o, 8'h00);
    $display("test hardware protect done");
  endtask : t_hpm

  task automatic t_cfg();
    logic [3:0] dt [4] = '{4'h3, 4'h2, 4'h4, 4'h5};
    logic [7:0] e;
    for (int k = 0; k < 8; k++) begin
      e = {2'h0, k[2:1], ~k[2:1], 2'h0};
      @(posedge clock_i);
      cfg_wr_i <= 1'b1;
      cfg_data_i <= e | 8'hc3;
      quad_mode_i <= k[0];
      @(posedge clock_i);
      cfg_wr_i <= 1'b0;
      clks(4);
      chk("cfg", cfg_byte_o, e);
      chk("drive", {6'h00, drive_sel_o}, {6'h00, ~k[2:1]});
      chk("dummy", {4'h0, dummy_clks_o}, {4'h0, dt[k[2:1]] << k[0]});
      if (!k[0]) begin
        frm(fsp_pkg::OPC_READ_CONFIG, 8'h00, 32);
        chk("rd_cfg", rd[15:8], e);
        chk("rd_rep", rd[7:0], e);
      end
    end
    quad_mode_i <= 1'b0;
    $display("test config done");
  endtask : t_cfg

  task automatic t_otp();
    otp_mode_i <= 1'b1;
    clks(4);
    pe(fsp_pkg::FSP_SECT, 24'h000000, 1'b1, 1'b1, 1'b1);
    write_status_cmd(8'h1c);
    chk("otp_view", stat_byte_o, 8'h18);
    hold_n_i <= 1'b0;
    clks(6);
    chk("hold", {6'h00, hold_act_o, rst_act_o}, 8'h02);
    hold_n_i <= 1'b1;
    write_status_cmd(8'h20);
    hold_n_i <= 1'b0;
    clks(6);
    chk("pin_rst", {6'h00, hold_act_o, rst_act_o}, 8'h01);
    hold_n_i <= 1'b1;
    write_status_cmd(8'h40);
    hold_n_i <= 1'b0;
    clks(6);
    chk("pins_off", {6'h00, hold_act_o, rst_act_o}, 8'h00);
    hold_n_i <= 1'b1;
    write_status_cmd(8'h80);
    chk("otp_once", stat_byte_o, 8'hf8);
    pe(fsp_pkg::FSP_SECT, 24'h000000, 1'b1, 1'b1, 1'b0);
    otp_mode_i <= 1'b0;
    $display("test otp done");
  endtask : t_otp

  //////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst_i = 1'b0;
    wp_n_i = 1'b1;
    hold_n_i = 1'b1;
    otp_mode_i = 1'b0;
    quad_mode_i = 1'b0;
    pe_i = '0;
    pe_done_i = 1'b0;
    cfg_wr_i = 1'b0;
    cfg_data_i = 8'h00;
    // A clean rising edge, so the link-side reset is never missed
    #1 sys_rst_i = 1'b1;
    clks(8);
    sys_rst_i <= 1'b0;
    clks(4);
    t_wel();
    t_prot();
    t_hpm();
    t_cfg();
    t_otp();
    tally_and_finish();
  end
endmodule : tb_top
